//--- design/lin_status_pkg.sv
package lin_status_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h04;
	localparam logic [7:0] OFS_CONTROL = 8'h30;
	localparam logic [7:0] OFS_STATUS = 8'h38;
	localparam logic [7:0] OFS_MASK = 8'h3c;
	localparam int ADDR_W = 8;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int ST_HDET = 0;
	localparam int ST_HERR = 1;
	localparam int ST_IDPERR = 2;
	localparam int ST_SYNC = 3;
	localparam int ST_BREAK = 8;
	localparam int ST_MISMATCH = 9;
	localparam int CT_RESP_EN = 0;
	localparam int CT_HDET_EN = 1;
	localparam int CT_ARS_EN = 2;
	localparam int CT_IDP_EN = 9;
	localparam int CT_BRK_EN = 10;
	localparam int CT_MIS_EN = 12;
	localparam int IE_LIN = 8;

	// ------------------------------------------------------------
	// implemented bits and reset values
	// ------------------------------------------------------------
	localparam logic [31:0] STATUS_BITS = 32'h0000030f;
	localparam logic [31:0] CONTROL_BITS = 32'h00001607;
	localparam logic [31:0] IRQ_ENABLE_BITS = 32'h00000100;
	localparam logic [31:0] STATUS_RESET = 32'h00000000;
	localparam logic [31:0] CONTROL_RESET = 32'h00000000;
	localparam logic [31:0] IRQ_ENABLE_RESET = 32'h00000000;
	localparam logic [31:0] MASK_RESET = 32'h00000000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// events from the uart core, same clock
	// ------------------------------------------------------------
	typedef struct packed {
		logic tx_active;
		logic bit_sample;
		logic break_detected;
		logic sync_start;
		logic sync_done;
		logic header_error;
		logic id_parity_error;
		logic header_detected;
	} lin_events_s;
endpackage

//--- design/lin_status_flags.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module lin_status_flags (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [lin_status_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [lin_status_pkg::ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic serial_in_pin,
	input wire logic serial_out_pin,
	input wire lin_status_pkg::lin_events_s events,
	output logic baud_reload,
	output logic header_restart,
	output logic irq
);
	import lin_status_pkg::*;

	// ------------------------------------------------------------
	// serial input synchroniser
	// ------------------------------------------------------------
	logic sin_s1_r, sin_s2_r, sin_s3_r, rx_level_r;
	logic rx_level_nxt;

	// a level only counts once the last two stages agree
	always_comb begin
		rx_level_nxt = rx_level_r;
		if (sin_s2_r == sin_s3_r) begin
			rx_level_nxt = sin_s3_r;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sin_s1_r <= 1'b1;
			sin_s2_r <= 1'b1;
			sin_s3_r <= 1'b1;
			rx_level_r <= 1'b1;
		end else begin
			sin_s1_r <= serial_in_pin;
			sin_s2_r <= sin_s1_r;
			sin_s3_r <= sin_s2_r;
			rx_level_r <= rx_level_nxt;
		end
	end

	// ------------------------------------------------------------
	// axi4-lite write and read channels
	// ------------------------------------------------------------
	logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
	logic aw_got_nxt, w_got_nxt, bvalid_nxt, rvalid_nxt;
	logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic do_write;
	logic [31:0] wmask;
	logic [31:0] control_r, control_nxt, irq_en_r, irq_en_nxt;
	logic [31:0] mask_r, mask_nxt, status_r, status_nxt;
	logic wr_status, wr_control, wr_irq_en, wr_mask, wr_hit;

	assign s_axi_awready = !aw_got_r && !bvalid_r;
	assign s_axi_wready = !w_got_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign do_write = aw_got_r && w_got_r && !bvalid_r;

	always_comb begin
		wr_status = 1'b0;
		wr_control = 1'b0;
		wr_irq_en = 1'b0;
		wr_mask = 1'b0;
		if (awaddr_r == OFS_STATUS) begin
			wr_status = do_write;
		end else if (awaddr_r == OFS_CONTROL) begin
			wr_control = do_write;
		end else if (awaddr_r == OFS_IRQ_ENABLE) begin
			wr_irq_en = do_write;
		end else if (awaddr_r == OFS_MASK) begin
			wr_mask = do_write;
		end
		wr_hit = wr_status || wr_control || wr_irq_en || wr_mask;
	end

	always_comb begin
		aw_got_nxt = aw_got_r;
		w_got_nxt = w_got_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_got_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_got_nxt = 1'b1;
			wdata_nxt = s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
				{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
		end
		if (do_write) begin
			aw_got_nxt = 1'b0;
			w_got_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
	end

	// unmasked lanes stay zero, so partial writes keep other status bits but clear other control, irq enable and mask bytes
	assign wmask = wdata_r;

	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = RESP_OKAY;
			if (s_axi_araddr == OFS_STATUS) begin
				rdata_nxt = status_r & STATUS_BITS;
			end else if (s_axi_araddr == OFS_CONTROL) begin
				rdata_nxt = control_r;
			end else if (s_axi_araddr == OFS_IRQ_ENABLE) begin
				rdata_nxt = irq_en_r;
			end else if (s_axi_araddr == OFS_MASK) begin
				rdata_nxt = mask_r;
			end else begin
				rdata_nxt = 32'h00000000;
				rresp_nxt = RESP_SLVERR;
			end
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 32'h00000000;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= RESP_OKAY;
		end else begin
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// ------------------------------------------------------------
	// flags, control and interrupt
	// ------------------------------------------------------------
	logic [31:0] set_bits, clr_bits;
	logic resp_en, mis_en, brk_en;
	logic sync_w1, baud_reload_r, baud_reload_nxt;

	assign resp_en = control_r[CT_RESP_EN];
	assign mis_en = control_r[CT_MIS_EN];
	assign brk_en = control_r[CT_BRK_EN];
	assign sync_w1 = wr_status && wmask[ST_SYNC];

	always_comb begin
		set_bits = 32'h00000000;
		clr_bits = 32'h00000000;
		set_bits[ST_MISMATCH] = mis_en && events.tx_active && events.bit_sample
			&& (rx_level_r != serial_out_pin);
		set_bits[ST_BREAK] = brk_en && events.break_detected;
		set_bits[ST_SYNC] = resp_en && control_r[CT_ARS_EN]
			&& events.sync_start;
		set_bits[ST_HERR] = resp_en && control_r[CT_HDET_EN] && events.header_error;
		set_bits[ST_IDPERR] = resp_en && control_r[CT_IDP_EN]
			&& events.id_parity_error;
		set_bits[ST_HDET] = resp_en && control_r[CT_HDET_EN] && events.header_detected;
		// analysis ends with the sync field, when responder mode is left or when auto resync is switched off
		clr_bits[ST_SYNC] = events.sync_done || !resp_en || !control_r[CT_ARS_EN];
		if (wr_status) begin
			clr_bits = clr_bits | (wmask & STATUS_BITS);
		end
		// a new event in the clearing cycle survives
		status_nxt = ((status_r & ~clr_bits) | set_bits) & STATUS_BITS;
		control_nxt = wr_control ? (wmask & CONTROL_BITS) : control_r;
		irq_en_nxt = wr_irq_en ? (wmask & IRQ_ENABLE_BITS) : irq_en_r;
		mask_nxt = wr_mask ? (wmask & STATUS_BITS) : mask_r;
		baud_reload_nxt = sync_w1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_r <= STATUS_RESET;
			control_r <= CONTROL_RESET;
			irq_en_r <= IRQ_ENABLE_RESET;
			mask_r <= MASK_RESET;
			baud_reload_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
			control_r <= control_nxt;
			irq_en_r <= irq_en_nxt;
			mask_r <= mask_nxt;
			baud_reload_r <= baud_reload_nxt;
		end
	end

	// one pulse drives both the divisor reload and the header search reset
	assign baud_reload = baud_reload_r;
	assign header_restart = baud_reload_r;
	assign irq = irq_en_r[IE_LIN] && |(status_r & mask_r);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_mismatch_set: assert property (set_bits[ST_MISMATCH] |=> status_r[ST_MISMATCH])
		else $error("mismatch not flagged");
	a_mismatch_irq: assert property (status_r[ST_MISMATCH] && mask_r[ST_MISMATCH]
		&& irq_en_r[IE_LIN] |-> irq)
		else $error("mismatch irq missing");
	a_mismatch_gate: assert property (!mis_en && !status_r[ST_MISMATCH]
		|=> !status_r[ST_MISMATCH])
		else $error("mismatch set while disabled");
	a_break_hold: assert property (status_r[ST_BREAK] && !(wr_status && wmask[ST_BREAK])
		|=> status_r[ST_BREAK])
		else $error("break flag lost");
	a_break_set: assert property (set_bits[ST_BREAK] |=> status_r[ST_BREAK])
		else $error("break not flagged");
	a_break_gate: assert property (!brk_en && !status_r[ST_BREAK]
		|=> !status_r[ST_BREAK])
		else $error("break set while disabled");
	a_sync_set: assert property (set_bits[ST_SYNC] |=> status_r[ST_SYNC])
		else $error("sync flag not raised");
	a_sync_end: assert property (status_r[ST_SYNC] && events.sync_done
		&& !events.sync_start |=> !status_r[ST_SYNC])
		else $error("sync flag stuck");
	a_sync_restart: assert property (sync_w1 && !set_bits[ST_SYNC]
		|=> baud_reload && header_restart && !status_r[ST_SYNC] ##1 !baud_reload)
		else $error("sync restart wrong");
	a_irq_off: assert property (!irq_en_r[IE_LIN] |-> !irq)
		else $error("irq while disabled");
	a_sync_gate: assert property (!resp_en |=> !status_r[ST_SYNC])
		else $error("sync flag outside responder mode");
	a_reset_zero: assert property (disable iff (1'b0) !aresetn |=> status_r == 32'h0)
		else $error("status not zero after reset");
	a_herr_set: assert property (set_bits[ST_HERR] |=> status_r[ST_HERR])
		else $error("header error not flagged");
	a_idp_set: assert property (set_bits[ST_IDPERR] |=> status_r[ST_IDPERR])
		else $error("parity error not flagged");
	a_rsvd_zero: assert property ((status_r & ~STATUS_BITS) == 32'h0)
		else $error("reserved status bit set");
	a_bresp_time: assert property (do_write |=> s_axi_bvalid)
		else $error("write response late");

	c_mismatch: cover property (set_bits[ST_MISMATCH] ##1 irq);
	c_break_clear: cover property (status_r[ST_BREAK] ##[1:20] !status_r[ST_BREAK]);
	c_sync_restart: cover property (status_r[ST_SYNC] && sync_w1);
	c_set_clear_race: cover property (wr_status && |(wmask & set_bits));
	c_sync_done: cover property (status_r[ST_SYNC] ##1 !status_r[ST_SYNC]);
endmodule
`default_nettype wire

//--- bench/lin_bus_node.sv
`timescale 1ns/1ns
`default_nettype none
module lin_bus_node (
	input wire logic aclk,
	input wire logic serial_out_pin,
	input wire logic hold_dominant,
	output logic serial_in_pin
);
	// ------
	// wired-and bus
	// ------
	// pull-up makes recessive the idle level; any node holding dominant wins,
	// one cycle of transceiver loop delay
	always_ff @(posedge aclk) begin
		serial_in_pin <= serial_out_pin & ~hold_dominant;
	end
endmodule
`default_nettype wire

//--- bench/test_lin_status_flags.sv
`timescale 1ns/1ns
`default_nettype none
module test_lin_status_flags;
	import lin_status_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic serial_out_pin = 1'b1, serial_in_pin, hold_dominant = 1'b0;
	logic baud_reload, header_restart;
	lin_events_s events = '0;
	lin_events_s evs[5] = '{8'h20, 8'h10, 8'h04, 8'h02, 8'h01};
	logic [31:0] exp = 32'h0, ctl = 32'h0, ien = 32'h0, msk = 32'h0, rd, rnd;
	int seed = 32'h012eb199;
	int mismatches = 0, checks = 0, reloads = 0, restarts = 0, exp_reloads = 0;

	always #4 aclk = ~aclk;
	always @(posedge aclk) begin
		if (baud_reload === 1'b1) reloads++;
		if (header_restart === 1'b1) restarts++;
	end

	lin_status_flags lin_status_flags_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
		.s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .serial_in_pin,
		.serial_out_pin, .events, .baud_reload, .header_restart, .irq);
	lin_bus_node lin_bus_node_inst (.aclk, .serial_out_pin, .hold_dominant, .serial_in_pin);

	// ------
	// expectations and checks
	// ------
	function automatic logic [31:0] after_events(logic [31:0] s, lin_events_s e,
		logic [31:0] c, logic diff);
		logic rsp;
		rsp = c[CT_RESP_EN];
		if (e.break_detected && c[CT_BRK_EN]) s[ST_BREAK] = 1'b1;
		if (e.tx_active && e.bit_sample && diff && c[CT_MIS_EN]) s[ST_MISMATCH] = 1'b1;
		if (e.header_error && rsp && c[CT_HDET_EN]) s[ST_HERR] = 1'b1;
		if (e.id_parity_error && rsp && c[CT_IDP_EN]) s[ST_IDPERR] = 1'b1;
		if (e.header_detected && rsp && c[CT_HDET_EN]) s[ST_HDET] = 1'b1;
		if (e.sync_done) s[ST_SYNC] = 1'b0;
		if (e.sync_start && rsp && c[CT_ARS_EN]) s[ST_SYNC] = 1'b1;
		if (!(rsp && c[CT_ARS_EN])) s[ST_SYNC] = 1'b0;
		return s;
	endfunction

	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] want);
		checks++;
		if (got !== want) begin
			mismatches++;
			$display("[ERR] %0t word %h expected %h", $time, got, want);
		end
	endtask

	task automatic chk_bit(input logic got, input logic want);
		checks++;
		if (got !== want) begin
			mismatches++;
			$display("[ERR] %0t bit %b expected %b", $time, got, want);
		end
	endtask

	// one transfer; waits for the answer, never for a fixed count
	task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		logic aw, w, ar, b;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_arvalid <= ~wr;
		s_axi_bready <= wr;
		s_axi_rready <= ~wr;
		for (n = 0; n < 40; n++) begin
			@(negedge aclk);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			ar = s_axi_arvalid & s_axi_arready;
			b = wr ? s_axi_bvalid : s_axi_rvalid;
			rr = wr ? s_axi_bresp : s_axi_rresp;
			rd = s_axi_rdata;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (ar) s_axi_arvalid <= 1'b0;
			if (b) break;
		end
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		if (n == 40) begin
			mismatches++;
			$display("[ERR] %0t bus answer timed out", $time);
			complete_run();
		end
	endtask

	task automatic pulse(input lin_events_s e, input logic diff);
		@(posedge aclk);
		events <= e;
		@(posedge aclk);
		events <= '0;
		exp = after_events(exp, e, ctl, diff);
	endtask

	task automatic write_status(input logic [31:0] d);
		axi(1'b1, OFS_STATUS, d);
		chk_word({30'h0, rr}, {30'h0, RESP_OKAY});
		exp = exp & ~(d & STATUS_BITS);
		if (d[ST_SYNC]) exp_reloads++;
	endtask

	task automatic set_regs(input logic [31:0] c, input logic [31:0] ie, input logic [31:0] m);
		axi(1'b1, OFS_CONTROL, c);
		axi(1'b1, OFS_IRQ_ENABLE, ie);
		axi(1'b1, OFS_MASK, m);
		ctl = c;
		ien = ie;
		msk = m;
		exp = after_events(exp, '0, ctl, 1'b0);
	endtask

	task automatic check_status;
		axi(1'b0, OFS_STATUS, 32'h0);
		chk_word(rd, exp);
		chk_word({30'h0, rr}, {30'h0, RESP_OKAY});
		chk_bit(irq, ien[IE_LIN] & |(exp & msk));
		chk_word(reloads, exp_reloads);
		chk_word(restarts, exp_reloads);
	endtask

	// ------
	// sequence
	// ------
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		check_status();
		axi(1'b0, 8'h80, 32'h0);
		chk_word(rd, 32'h0);
		chk_word({30'h0, rr}, {30'h0, RESP_SLVERR});
		set_regs(CONTROL_BITS, IRQ_ENABLE_BITS, STATUS_BITS);
		foreach (evs[i]) begin
			pulse(evs[i], 1'b0);
			check_status();
			write_status(32'h0);
			check_status();
			write_status(32'hffffffff);
			check_status();
		end
		// dominant echo while sending recessive is a collision
		hold_dominant <= 1'b1;
		repeat (6) @(posedge aclk);
		pulse(8'hc0, 1'b1);
		check_status();
		write_status(32'h200);
		hold_dominant <= 1'b0;
		repeat (6) @(posedge aclk);
		pulse(8'hc0, 1'b0);
		check_status();
		set_regs(32'h0207, IRQ_ENABLE_BITS, STATUS_BITS);
		hold_dominant <= 1'b1;
		repeat (6) @(posedge aclk);
		pulse(8'he0, 1'b1);
		check_status();
		hold_dominant <= 1'b0;
		set_regs(CONTROL_BITS, IRQ_ENABLE_BITS, STATUS_BITS);
		pulse(8'h10, 1'b0);
		pulse(8'h08, 1'b0);
		check_status();
		pulse(8'h10, 1'b0);
		set_regs(32'h0006, IRQ_ENABLE_BITS, STATUS_BITS);
		check_status();
		pulse(8'h10, 1'b0);
		check_status();
		set_regs(CONTROL_BITS, IRQ_ENABLE_BITS, 32'h0);
		pulse(8'h20, 1'b0);
		check_status();
		set_regs(CONTROL_BITS, 32'h0, STATUS_BITS);
		check_status();
		// mid-run reset with a flag standing must drop it
		pulse(8'h20, 1'b0);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		exp = STATUS_RESET;
		ctl = CONTROL_RESET;
		ien = IRQ_ENABLE_RESET;
		msk = MASK_RESET;
		check_status();
		repeat (40) begin
			set_regs($random(seed) & CONTROL_BITS, IRQ_ENABLE_BITS, $random(seed));
			rnd = $random(seed);
			pulse(rnd[7:0] & 8'h37, 1'b0);
			check_status();
			write_status($random(seed));
			check_status();
		end
		complete_run();
	end
endmodule
`default_nettype wire
